// ### hdl/swk_pkg.sv
// stop-mode wake controller: shared constants, states and carrier structs
// assumes one always-running wake clock; all raw sources are asynchronous
package swk_pkg;

    // source counts per class
    localparam int SWK_NPIN   = 66;
    localparam int SWK_NI2C   = 2;
    localparam int SWK_NTPM   = 3;
    localparam int SWK_NUART  = 3;
    localparam int SWK_NSAI   = 2;
    localparam int SWK_NCAN   = 2;

    // interrupt controller geometry
    localparam int SWK_PRIO_W = 4;                      // bits per priority field
    localparam int SWK_NLEVEL = 16;                     // nested priority levels
    localparam int SWK_NVEC   = 240;                    // interrupt vectors
    localparam int SWK_VEC_W  = 8;

    // wake source indices, one pending bit each
    localparam int SWK_NSRC   = 20;
    localparam int SWK_IDX_W  = 5;
    localparam int S_RSTPIN   = 0;
    localparam int S_DBGRST   = 1;
    localparam int S_WATCHDOG_TIMER     = 2;
    localparam int S_LVD      = 3;
    localparam int S_LVW      = 4;
    localparam int S_HVD      = 5;
    localparam int S_PIN      = 6;
    localparam int S_ADC      = 7;
    localparam int S_CMP      = 8;
    localparam int S_I2C      = 9;
    localparam int S_CFGIO    = 10;
    localparam int S_TPM      = 11;
    localparam int S_UART     = 12;
    localparam int S_LOW_POWER_UART   = 13;
    localparam int S_USB      = 14;
    localparam int S_LOW_POWER_TIMER    = 15;
    localparam int S_RTC      = 16;
    localparam int S_SAI      = 17;
    localparam int S_CAN      = 18;
    localparam int S_NMI      = 19;

    // first vector used for wake sources; vector = base + source index
    localparam logic [SWK_VEC_W-1:0] SWK_VEC_BASE = 8'h10;
    localparam logic [SWK_NSRC-1:0]  SWK_PEND_RST = 20'h00000;

    // stages before edge history shows real line levels after reset
    localparam int SWK_HIST_D = 3;

    // power modes as driven by the mode controller
    typedef enum logic [1:0] {
        PM_RUN   = 2'b00,
        PM_PSTOP = 2'b01,
        PM_STOP  = 2'b10,
        PM_VERY_LOW_POWER_STOP  = 2'b11
    } swk_pmode_t;

    // controller states
    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_ARMED   = 2'b01,
        ST_WAKE    = 2'b10,
        ST_DELIVER = 2'b11
    } swk_state_t;

    // asynchronous raw wake inputs
    typedef struct packed {
        logic                 rst_pin;
        logic                 dbg_rst;
        logic                 watchdog_timer_rst;
        logic                 lvd;
        logic                 lvw;
        logic                 hvd;
        logic [SWK_NPIN-1:0]  pin_flag;
        logic                 adc_irq;
        logic                 cmp_irq;
        logic [SWK_NI2C-1:0]  i2c_irq;
        logic                 cfgio_irq;
        logic [SWK_NTPM-1:0]  tpm_irq;
        logic [SWK_NUART-1:0] uart_rx;
        logic                 low_power_uart_irq;
        logic                 usb_wake;
        logic                 low_power_timer_irq;
        logic                 rtc_irq;
        logic [SWK_NSAI-1:0]  sai_irq;
        logic [SWK_NCAN-1:0]  can_rx;
        logic                 nmi;
    } swk_raw_t;

    // static qualifiers (configuration, same clock domain)
    typedef struct packed {
        logic [SWK_NPIN-1:0]  pin_en;
        logic                 watchdog_timer_on_lpo;
        logic                 adc_int_clk;
        logic                 cmp_trig_mode;
        logic [SWK_NI2C-1:0]  i2c_clk_on;
        logic                 cfgio_clk_on;
        logic [SWK_NTPM-1:0]  tpm_clk_on;
        logic                 low_power_uart_clk_on;
        logic                 low_power_timer_clk_on;
        logic [SWK_NSAI-1:0]  sai_ext_clk;
    } swk_qual_t;

    // request toward the interrupt controller
    typedef struct packed {
        logic                  valid;
        logic [SWK_VEC_W-1:0]  vec;
        logic [SWK_PRIO_W-1:0] prio;
    } swk_irq_t;

    typedef logic [SWK_NSRC-1:0][SWK_PRIO_W-1:0] swk_prio_tab_t;

endpackage : swk_pkg

// ### hdl/swk_prio_sel.sv
// stop-mode wake controller: picks the most urgent pending wake source
// assumes pending mask and priority table come from the same clock domain
`timescale 1ns/1ps
module swk_prio_sel
    import swk_pkg::*;
(
    // pending sources and their priorities
    input  wire logic [swk_pkg::SWK_NSRC-1:0]   pend,
    input  wire swk_pkg::swk_prio_tab_t         prio,
    // selection
    output logic                                hit,
    output logic [swk_pkg::SWK_IDX_W-1:0]       idx,
    output logic [swk_pkg::SWK_PRIO_W-1:0]      lvl
);

    // lowest value wins; ties go to the lowest index
    always_comb
    begin
        hit = 1'b0;
        idx = '0;
        lvl = '1;
        for (int i = 0; i < SWK_NSRC; i++)
        begin
            if (pend[i] && (!hit || prio[i] < lvl))
            begin
                hit = 1'b1;
                idx = SWK_IDX_W'(i);
                lvl = prio[i];
            end
        end
    end

endmodule : swk_prio_sel

// ### hdl/swk_wake_ctrl.sv
// stop-mode wake controller: latches wake events while stopped, asks the
// clock control logic to restart, then hands pending vectors to the
// nested interrupt unit one at a time
// assumes clock keeps running in every stop mode; raw sources are async
`timescale 1ns/1ps

module swk_wake_ctrl
    import swk_pkg::*;
(
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       sys_rst,
    // mode controller and clock control
    input  wire swk_pkg::swk_pmode_t        pmode,
    input  wire logic                       clk_running,
    // wake sources
    input  wire swk_pkg::swk_raw_t          raw_in,
    input  wire swk_pkg::swk_qual_t         qual_in,
    // nested interrupt unit
    input  wire swk_pkg::swk_prio_tab_t     prio_tab,
    input  wire logic                       irq_taken,
    // outputs
    output swk_pkg::swk_irq_t               irq_out,
    output logic                            clk_restart_req,
    output logic [swk_pkg::SWK_NSRC-1:0]    wake_pend,
    output swk_pkg::swk_state_t             wake_state
);

    localparam int RAW_W = $bits(swk_raw_t);

    // vector number of a source
    function automatic logic [SWK_VEC_W-1:0] src_vec(input logic [SWK_IDX_W-1:0] i);
        src_vec = SWK_VEC_BASE + {{(SWK_VEC_W-SWK_IDX_W){1'b0}}, i};
    endfunction : src_vec

    // stop-mode test, used by arming and by the event gate
    function automatic logic is_stop(input swk_pmode_t m);
        is_stop = (m == PM_PSTOP) || (m == PM_STOP) || (m == PM_VERY_LOW_POWER_STOP);
    endfunction : is_stop

    // synchroniser and edge history
    logic [RAW_W-1:0]           sync1_r;
    logic [RAW_W-1:0]           sync2_r;
    logic [RAW_W-1:0]           prev_r;
    swk_raw_t                   cur;
    swk_raw_t                   old;
    logic [SWK_HIST_D-1:0]      hist_r;
    logic                       hist_ok;

    // controller state
    swk_state_t                 state_r;
    swk_state_t                 state_nxt;
    logic [SWK_NSRC-1:0]        pend_r;
    logic [SWK_NSRC-1:0]        pend_nxt;
    logic                       req_r;
    logic                       req_nxt;
    swk_irq_t                   irq_r;
    swk_irq_t                   irq_nxt;
    logic [SWK_IDX_W-1:0]       idx_r;
    logic [SWK_IDX_W-1:0]       idx_nxt;

    // event terms
    logic [SWK_NSRC-1:0]        ev;
    logic [SWK_NSRC-1:0]        ev_set;
    logic [SWK_NSRC-1:0]        ev_clr;
    logic                       armed;
    logic                       sel_hit;
    logic [SWK_IDX_W-1:0]       sel_idx;
    logic [SWK_PRIO_W-1:0]      sel_lvl;
    logic                       any_pend;
    logic                       take_now;

    // two-stage synchroniser over every raw source
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
            hist_r  <= '0;
        end
        else
        begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
            hist_r  <= {hist_r[SWK_HIST_D-2:0], 1'b1};
        end
    end

    assign cur = swk_raw_t'(sync2_r);
    assign old = swk_raw_t'(prev_r);

    // history valid once real line levels reached the last stage
    assign hist_ok = hist_r[SWK_HIST_D-1];

    // system resets as wake sources
    assign ev[S_RSTPIN] = cur.rst_pin;
    assign ev[S_DBGRST] = cur.dbg_rst;
    assign ev[S_WATCHDOG_TIMER]   = cur.watchdog_timer_rst & qual_in.watchdog_timer_on_lpo;

    // power monitor levels
    assign ev[S_LVD]    = cur.lvd;
    assign ev[S_LVW]    = cur.lvw;
    assign ev[S_HVD]    = cur.hvd;

    // enabled pin interrupts
    assign ev[S_PIN]    = |(cur.pin_flag & qual_in.pin_en);

    // clock-qualified analog and peripheral sources
    assign ev[S_ADC]    = cur.adc_irq & qual_in.adc_int_clk;
    assign ev[S_CMP]    = cur.cmp_irq & qual_in.cmp_trig_mode;
    assign ev[S_I2C]    = |(cur.i2c_irq & qual_in.i2c_clk_on);
    assign ev[S_CFGIO]  = cur.cfgio_irq & qual_in.cfgio_clk_on;
    assign ev[S_TPM]    = |(cur.tpm_irq & qual_in.tpm_clk_on);
    assign ev[S_LOW_POWER_UART] = cur.low_power_uart_irq & qual_in.low_power_uart_clk_on;
    assign ev[S_LOW_POWER_TIMER]  = cur.low_power_timer_irq & qual_in.low_power_timer_clk_on;
    assign ev[S_SAI]    = |(cur.sai_irq & qual_in.sai_ext_clk);

    // line edges: start-bit fall on uart, either edge on can; held off
    // until history is valid, so an idle line gives no false edge at reset
    assign ev[S_UART]   = hist_ok & (|(old.uart_rx & ~cur.uart_rx));
    assign ev[S_CAN]    = hist_ok & (|(old.can_rx ^ cur.can_rx));

    // always-on sources
    assign ev[S_USB]    = cur.usb_wake;
    assign ev[S_RTC]    = cur.rtc_irq;
    assign ev[S_NMI]    = cur.nmi;

    // event capture only while stopped
    assign armed    = (state_r == ST_ARMED) || (state_r == ST_WAKE);
    assign ev_set   = armed && is_stop(pmode) ? ev : '0;
    assign take_now = (state_r == ST_DELIVER) && irq_r.valid && irq_taken;
    assign ev_clr   = take_now ? (SWK_NSRC'(1) << idx_r) : '0;
    assign pend_nxt = (pend_r & ~ev_clr) | ev_set;
    assign any_pend = |pend_r;

    // most urgent pending source
    swk_prio_sel u_sel (
        .pend (pend_r & ~ev_clr),
        .prio (prio_tab),
        .hit  (sel_hit),
        .idx  (sel_idx),
        .lvl  (sel_lvl)
    );

    // next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
                if (is_stop(pmode))
                    state_nxt = ST_ARMED;
            ST_ARMED:
                if (any_pend)
                    state_nxt = ST_WAKE;
                else if (!is_stop(pmode))
                    state_nxt = ST_RUN;
            ST_WAKE:
                if (clk_running)
                    state_nxt = ST_DELIVER;
            ST_DELIVER:
                if (take_now && !sel_hit)
                    state_nxt = ST_RUN;
            default:
                state_nxt = ST_RUN;
        endcase
    end

    // restart request: raised on any pending, held until all taken
    assign req_nxt = (state_nxt == ST_WAKE) || (state_nxt == ST_DELIVER);

    // vector hand-off; next one follows after one empty cycle after a take
    always_comb
    begin
        irq_nxt = irq_r;
        idx_nxt = idx_r;
        if (state_nxt != ST_DELIVER)
        begin
            irq_nxt.valid = 1'b0;
        end
        else if (!irq_r.valid || take_now)
        begin
            irq_nxt.valid = sel_hit && !take_now;
            irq_nxt.vec   = src_vec(sel_idx);
            irq_nxt.prio  = sel_lvl;
            idx_nxt       = sel_idx;
        end
    end

    // state registers
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= ST_RUN;
            pend_r  <= SWK_PEND_RST;
            req_r   <= 1'b0;
            irq_r   <= '0;
            idx_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            pend_r  <= pend_nxt;
            req_r   <= req_nxt;
            irq_r   <= irq_nxt;
            idx_r   <= idx_nxt;
        end
    end

    // outputs straight from flops
    assign irq_out         = irq_r;
    assign clk_restart_req = req_r;
    assign wake_pend       = pend_r;
    assign wake_state      = state_r;

endmodule : swk_wake_ctrl

// ### tb/swk_wake_monitor.sv
// stop-mode wake controller: concurrent checks on the top ports
// assumes bound to swk_wake_ctrl, one clock, async active-high reset
`timescale 1ns/1ps
module swk_wake_monitor
    import swk_pkg::*;
(
    // clock and reset
    input wire logic                   clock,
    input wire logic                   sys_rst,
    // inputs of the design
    input wire swk_pkg::swk_pmode_t    pmode,
    input wire logic                   clk_running,
    input wire swk_pkg::swk_raw_t      raw_in,
    input wire swk_pkg::swk_qual_t     qual_in,
    input wire swk_pkg::swk_prio_tab_t prio_tab,
    input wire logic                   irq_taken,
    // outputs of the design
    input wire swk_pkg::swk_irq_t      irq_out,
    input wire logic                   clk_restart_req,
    input wire logic [swk_pkg::SWK_NSRC-1:0] wake_pend,
    input wire swk_pkg::swk_state_t    wake_state
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // offset of the presented vector from the base
    wire logic [7:0] vec_off = irq_out.vec - SWK_VEC_BASE;
    // steps of a wake sequence
    sequence armed_nmi;
        (wake_state == ST_ARMED && !clk_running && raw_in.nmi) [*3];
    endsequence
    sequence taken_now;
        irq_out.valid && irq_taken;
    endsequence
    a_arm_entry:
        assert property (wake_state == ST_RUN && pmode != PM_RUN |=> wake_state == ST_ARMED)
        else $error("stop not armed");
    a_nmi_latch:
        assert property (armed_nmi |-> ##[0:2] wake_pend[S_NMI])
        else $error("event not latched");
    a_wake_req:
        assert property (wake_state == ST_ARMED && wake_pend != '0
            |=> wake_state == ST_WAKE && clk_restart_req)
        else $error("no restart request");
    a_req_hold:
        assert property (clk_restart_req == (wake_state == ST_WAKE || wake_state == ST_DELIVER))
        else $error("restart request wrong");
    a_deliver_entry:
        assert property (wake_state == ST_WAKE && clk_running
            |=> wake_state == ST_DELIVER && irq_out.valid)
        else $error("no delivery");
    a_valid_stand:
        assert property (irq_out.valid && !irq_taken |=> irq_out.valid && $stable(irq_out.vec))
        else $error("vector dropped");
    a_take_gap:
        assert property (taken_now |=> !irq_out.valid)
        else $error("no gap after take");
    a_vec_prio:
        assert property (irq_out.valid |-> vec_off < SWK_NSRC && wake_pend[vec_off[4:0]]
            && irq_out.prio == prio_tab[vec_off[4:0]])
        else $error("vector or priority wrong");
    a_qual_gate:
        assert property ((!$rose(wake_pend[S_WATCHDOG_TIMER]) || qual_in.watchdog_timer_on_lpo)
            && (!$rose(wake_pend[S_ADC]) || qual_in.adc_int_clk)
            && (!$rose(wake_pend[S_CMP]) || qual_in.cmp_trig_mode))
        else $error("unqualified source latched");
    a_clk_gate:
        assert property ((!$rose(wake_pend[S_PIN]) || (qual_in.pin_en != '0))
            && (!$rose(wake_pend[S_I2C]) || (qual_in.i2c_clk_on != '0))
            && (!$rose(wake_pend[S_TPM]) || (qual_in.tpm_clk_on != '0))
            && (!$rose(wake_pend[S_LOW_POWER_TIMER]) || qual_in.low_power_timer_clk_on)
            && (!$rose(wake_pend[S_SAI]) || (qual_in.sai_ext_clk != '0)))
        else $error("clock-gated source latched");
    a_run_hold:
        assert property (wake_state == ST_RUN |=> $stable(wake_pend))
        else $error("pending changed in run");
endmodule : swk_wake_monitor

bind swk_wake_ctrl swk_wake_monitor u_mon (.clock(clock), .sys_rst(sys_rst), .pmode(pmode),
    .clk_running(clk_running), .raw_in(raw_in), .qual_in(qual_in), .prio_tab(prio_tab),
    .irq_taken(irq_taken), .irq_out(irq_out), .clk_restart_req(clk_restart_req),
    .wake_pend(wake_pend), .wake_state(wake_state));

// ### tb/swk_partner.sv
// stop-mode wake controller: clock control and interrupt unit model
// assumes design outputs are registered on the same clock
`timescale 1ns/1ps
module swk_partner
    import swk_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // from the wake controller
    input  wire logic              clk_restart_req,
    input  wire swk_pkg::swk_irq_t irq_out,
    input  wire logic [3:0]        lag,
    // answers
    output logic                   clk_running,
    output logic                   irq_taken
);
    logic [3:0] wait_r;
    // waiting for a restart or a take, and whether the wait is over
    wire logic busy = (clk_restart_req && !clk_running) || (irq_out.valid && !irq_taken);
    wire logic due  = wait_r >= lag;
    // count lag cycles, then restart clocks or take one vector
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wait_r      <= 4'h0;
            clk_running <= 1'b0;
            irq_taken   <= 1'b0;
        end
        else
        begin
            wait_r      <= (busy && !due) ? wait_r + 4'h1 : 4'h0;
            clk_running <= clk_restart_req && (clk_running || due);
            irq_taken   <= irq_out.valid && !irq_taken && clk_running && due;
        end
    end
endmodule : swk_partner

// ### tb/tb.sv
// stop-mode wake controller: self-checking bench with random wake rounds
// assumes swk_partner answers restart and take requests
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
    import swk_pkg::*;
    logic          clock, sys_rst, clk_running, irq_taken, clk_restart_req;
    logic [3:0]    lag;
    swk_pmode_t    pmode;
    swk_raw_t      raw;
    swk_qual_t     qual;
    swk_prio_tab_t prio;
    swk_irq_t      irq_out;
    swk_state_t    wake_state;
    logic [SWK_NSRC-1:0] wake_pend;
    int            n_fail, num_checks, seed, cyc;
    // design and far-side model
    swk_wake_ctrl DUT (.clock(clock), .sys_rst(sys_rst), .pmode(pmode),
        .clk_running(clk_running), .raw_in(raw), .qual_in(qual), .prio_tab(prio),
        .irq_taken(irq_taken), .irq_out(irq_out), .clk_restart_req(clk_restart_req),
        .wake_pend(wake_pend), .wake_state(wake_state));
    swk_partner u_far (.clock(clock), .sys_rst(sys_rst), .clk_restart_req(clk_restart_req),
        .irq_out(irq_out), .lag(lag), .clk_running(clk_running), .irq_taken(irq_taken));
    // clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task complete_run;
        if (n_fail == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    // hang guard
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_fail++;
            complete_run();
        end
    end
    task tick;
        @(posedge clock);
        #1;
    endtask : tick
    // one stop round: random sources and qualifiers, then every vector in order
    task automatic round(input swk_pmode_t m);
        logic [SWK_NSRC-1:0] ex;
        logic [31:0] r, q, t;
        logic [1:0] c;
        int p, lo, g;
        r = $random(seed);
        q = $random(seed);
        p = r[21:16];
        lag = {1'b0, q[10:8]};
        for (int k = 0; k < SWK_NSRC; k++)
        begin
            t = $random(seed);
            prio[k] = t[3:0];
        end
        qual = '0;
        qual.watchdog_timer_on_lpo = q[0];
        qual.adc_int_clk = q[1];
        qual.cmp_trig_mode = q[2];
        qual.sai_ext_clk[0] = q[3];
        qual.low_power_timer_clk_on = q[4];
        qual.pin_en[p] = q[5];
        qual.i2c_clk_on[1] = q[6];
        qual.cfgio_clk_on = q[7];
        qual.tpm_clk_on[2] = q[11];
        qual.low_power_uart_clk_on = q[12];
        pmode = m;
        repeat (3) tick();
        `CHK(wake_state, ST_ARMED)
        raw.rst_pin = r[0];
        raw.dbg_rst = r[1];
        raw.watchdog_timer_rst = r[2];
        raw.pin_flag[p] = r[3];
        raw.adc_irq = r[4];
        raw.cmp_irq = r[5];
        raw.uart_rx[0] = !r[6];
        raw.can_rx[0] = raw.can_rx[0] ^ r[7];
        raw.sai_irq[0] = r[8];
        raw.low_power_timer_irq = r[9];
        raw.nmi = r[10];
        raw.i2c_irq[1] = r[11];
        raw.cfgio_irq = r[12];
        raw.tpm_irq[2] = r[13];
        raw.low_power_uart_irq = r[14];
        raw.usb_wake = r[15];
        raw.rtc_irq = r[22];
        raw.lvd = r[23];
        raw.lvw = r[24];
        raw.hvd = r[25];
        // expected pending mask, one bit per source index
        ex = '0;
        ex[S_RSTPIN] = r[0];
        ex[S_DBGRST] = r[1];
        ex[S_WATCHDOG_TIMER] = r[2] & q[0];
        ex[S_LVD] = r[23];
        ex[S_LVW] = r[24];
        ex[S_HVD] = r[25];
        ex[S_PIN] = r[3] & q[5];
        ex[S_ADC] = r[4] & q[1];
        ex[S_CMP] = r[5] & q[2];
        ex[S_I2C] = r[11] & q[6];
        ex[S_CFGIO] = r[12] & q[7];
        ex[S_TPM] = r[13] & q[11];
        ex[S_UART] = r[6];
        ex[S_LOW_POWER_UART] = r[14] & q[12];
        ex[S_USB] = r[15];
        ex[S_LOW_POWER_TIMER] = r[9] & q[4];
        ex[S_RTC] = r[22];
        ex[S_SAI] = r[8] & q[3];
        ex[S_CAN] = r[7];
        ex[S_NMI] = r[10];
        g = 0;
        while (wake_state !== ST_WAKE && g < 12)
        begin
            tick();
            g++;
        end
        `CHK(wake_pend, ex)
        c = raw.can_rx;
        raw = '0;
        raw.uart_rx = '1;
        raw.can_rx = c;
        g = 0;
        while (ex != '0 && g < 300)
        begin
            tick();
            g++;
            if (irq_out.valid === 1'b1 && irq_taken === 1'b1)
            begin
                lo = 0;
                for (int k = SWK_NSRC - 1; k >= 0; k--)
                    if (ex[k] && (!ex[lo] || prio[k] <= prio[lo])) lo = k;
                `CHK(irq_out.vec, SWK_VEC_BASE + 8'(lo))
                `CHK(irq_out.prio, prio[lo])
                ex[lo] = 1'b0;
            end
        end
        `CHK(ex, 20'h00000)
        repeat (2) tick();
        `CHK(clk_restart_req, 1'b0)
        `CHK(wake_pend, 20'h00000)
        pmode = PM_RUN;
        repeat (3) tick();
    endtask : round
    // reset, a run-mode event, then rounds over all stop modes
    initial
    begin
        seed = 58825;
        n_fail = 0;
        num_checks = 0;
        cyc = 0;
        sys_rst = 1'b1;
        lag = 4'h0;
        pmode = PM_RUN;
        raw = '0;
        raw.uart_rx = '1;
        qual = '0;
        prio = '0;
        repeat (8) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        raw.nmi = 1'b1;
        repeat (6) tick();
        `CHK(wake_pend, 20'h00000)
        `CHK(wake_state, ST_RUN)
        `CHK(clk_restart_req, 1'b0)
        `CHK(irq_out.valid, 1'b0)
        raw.nmi = 1'b0;
        repeat (4) tick();
        for (int i = 0; i < 24; i++)
            round(swk_pmode_t'(1 + i % 3));
        // reset in mid-wake: everything returns to idle
        pmode = PM_PSTOP;
        raw.nmi = 1'b1;
        repeat (6) tick();
        `CHK(clk_restart_req, 1'b1)
        sys_rst = 1'b1;
        pmode = PM_RUN;
        raw.nmi = 1'b0;
        repeat (2) tick();
        sys_rst = 1'b0;
        tick();
        `CHK(wake_pend, 20'h00000)
        `CHK(clk_restart_req, 1'b0)
        `CHK(irq_out.valid, 1'b0)
        `CHK(wake_state, ST_RUN)
        complete_run();
    end
endmodule : tb
